/* File: verilog/cops_cfg.svh */
// Constants for the port pattern setup block: encodings, field sizes, resets.
// Assumes inclusion by bare name from verilog/ sources.
`ifndef COPS_CFG_SVH
`define COPS_CFG_SVH

// Line rate codes: 0..9 CPRI options 1..10, 10..13 OBSAI 768..6144
`define COPS_RATE_W          4
`define COPS_RATE_CPRI_9     4'h8
`define COPS_RATE_CPRI_10    4'h9
`define COPS_RATE_OBSAI_LO   4'hA
`define COPS_RATE_MAX        4'hD
// PRBS order range
`define COPS_ORD_MIN         5'h0F
`define COPS_ORD_MAX         5'h1F
// User word width
`define COPS_USER_W          32
// Output word width and FIFO depth
`define COPS_WORD_W          32
`define COPS_FIFO_DEPTH      8
// Reset values
`define COPS_SEED_RST        32'hFFFFFFFF

`endif

/* File: verilog/cops_pkg.sv */
// Types for the port pattern setup block.
// Assumes nothing beyond a SystemVerilog compiler.
package cops_pkg;
  typedef enum logic [1:0] {COPS_MODE_OFF, COPS_MODE_NORMAL, COPS_MODE_THROUGH} cops_mode_t;
  typedef enum logic [1:0] {COPS_CONT_UNFRAMED, COPS_CONT_CPRI, COPS_CONT_OBSAI} cops_cont_t;
  typedef enum logic [1:0] {COPS_TIM_INTERNAL, COPS_TIM_EXTERNAL, COPS_TIM_GPS, COPS_TIM_RECEIVED} cops_tim_t;
  typedef enum logic [1:0] {COPS_PAT_PRBS, COPS_PAT_USER, COPS_PAT_OFF} cops_pat_t;
endpackage

/* File: verilog/cops_stream_if.sv */
// Valid/ready word stream between generator, FIFO and line side.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
`default_nettype none
interface cops_stream_if #(parameter int W = 32);
  logic [W-1:0] data;
  logic         valid;
  logic         ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

/* File: verilog/cops_fifo.sv */
// Synchronous FIFO with valid/ready on both sides.
// Assumes one clock; DEPTH is a power of two.
`timescale 1ns/1ps
`default_nettype none
module cops_fifo #(
  parameter int W     = 32,
  parameter int DEPTH = 8
) (
  input  wire logic ref_clk,
  input  wire logic arst_n,
  cops_stream_if.snk in_s,
  cops_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);
  initial if (DEPTH < 2 || (1 << AW) != DEPTH) $error("cops_fifo: DEPTH must be a power of two");

  logic [W-1:0]  mem [DEPTH];
  logic [AW:0]   wp_r;
  logic [AW:0]   wp_nxt;
  logic [AW:0]   rp_r;
  logic [AW:0]   rp_nxt;
  logic          full;
  logic          empty;
  logic          push;
  logic          pop;

  // Flags and handshakes
  always_comb
  begin
    empty      = (wp_r == rp_r);
    full       = (wp_r[AW-1:0] == rp_r[AW-1:0]) && (wp_r[AW] != rp_r[AW]);
    in_s.ready = !full;
    out_s.valid = !empty;
    out_s.data = mem[rp_r[AW-1:0]];
    push       = in_s.valid && !full;
    pop        = out_s.ready && !empty;
    wp_nxt     = push ? wp_r + 1'b1 : wp_r;
    rp_nxt     = pop ? rp_r + 1'b1 : rp_r;
  end

  // Pointers
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wp_r <= '0;
      rp_r <= '0;
    end
    else
    begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
    end
  end

  // Storage
  always_ff @(posedge ref_clk)
  begin
    if (push)
      mem[wp_r[AW-1:0]] <= in_s.data;
  end
endmodule
`default_nettype wire

/* File: verilog/cops_prbs.sv */
// Parallel PRBS generator, orders 15..31, standard maximal-length taps.
// Assumes order changes are followed by a reseed.
`timescale 1ns/1ps
`default_nettype none
`include "cops_cfg.svh"
module cops_prbs #(
  parameter int W = 32
) (
  input  wire logic         ref_clk,
  input  wire logic         arst_n,
  input  wire logic [4:0]   order,
  input  wire logic         reseed,
  input  wire logic         advance,
  output logic      [W-1:0] word
);
  initial if (W < 1 || W > 64) $error("cops_prbs: W out of range");

  logic [30:0] st_r;
  logic [30:0] st_nxt;
  logic [30:0] s;
  logic [W-1:0] w;
  logic [30:0] taps;
  logic        fb;

  // Feedback tap mask per order
  always_comb
  begin
    unique case (order)
      5'h0F: taps = 31'h0000_6000;                  // 15,14
      5'h10: taps = 31'h0000_B400;                  // 16,14,13,11
      5'h11: taps = 31'h0001_2000;                  // 17,14
      5'h12: taps = 31'h0002_0400;                  // 18,11
      5'h13: taps = 31'h0004_0023;                  // 19,6,2,1
      5'h14: taps = 31'h0009_0000;                  // 20,17
      5'h15: taps = 31'h0014_0000;                  // 21,19
      5'h16: taps = 31'h0030_0000;                  // 22,21
      5'h17: taps = 31'h0042_0000;                  // 23,18
      5'h18: taps = 31'h00E1_0000;                  // 24,23,22,17
      5'h19: taps = 31'h0120_0000;                  // 25,22
      5'h1A: taps = 31'h0200_0023;                  // 26,6,2,1
      5'h1B: taps = 31'h0400_0013;                  // 27,5,2,1
      5'h1C: taps = 31'h0900_0000;                  // 28,25
      5'h1D: taps = 31'h1400_0000;                  // 29,27
      5'h1E: taps = 31'h2000_0029;                  // 30,6,4,1
      default: taps = 31'h4800_0000;                // 31,28
    endcase
  end

  // W serial steps per word; Fibonacci LFSR, output is the new feedback bit
  always_comb
  begin
    s  = st_r;
    w  = '0;
    fb = 1'b0;
    for (int i = 0; i < W; i++)
    begin
      fb = ^(s & taps);
      w[W-1-i] = fb;
      s = {s[29:0], fb};
    end
    st_nxt = reseed ? 31'(`COPS_SEED_RST) : (advance ? s : st_r);
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_r <= 31'(`COPS_SEED_RST);
      word <= '0;
    end
    else
    begin
      st_r <= st_nxt;
      if (advance)
        word <= w;
    end
  end
endmodule
`default_nettype wire

/* File: verilog/cops_port.sv */
// Top of the port setup block: validates requested settings, generates the
// test word stream through an 8-word FIFO, drives the line word and enables.
// Assumes settings inputs are synchronous to ref_clk; clock detect is async.
`timescale 1ns/1ps
`default_nettype none
`include "cops_cfg.svh"
module cops_port
  import cops_pkg::*;
#(
  parameter int WORD_W     = `COPS_WORD_W,
  parameter int FIFO_DEPTH = `COPS_FIFO_DEPTH
) (
  input  wire logic                      ref_clk,
  input  wire logic                      arst_n,
  input  wire cops_mode_t                mode_req,
  input  wire cops_cont_t                content_req,
  input  wire logic [`COPS_RATE_W-1:0]   rate_req,
  input  wire cops_tim_t                 timing_req,
  input  wire logic                      error_correction_enable,
  input  wire cops_pat_t                 pattern_req,
  input  wire logic [4:0]                prbs_order_req,
  input  wire logic                      invert_req,
  input  wire logic [`COPS_USER_W-1:0]   user_word,
  input  wire logic                      ext_clk_det,
  input  wire logic                      gps_clk_det,
  input  wire logic                      rx_clk_det,
  input  wire logic [WORD_W-1:0]         rx_word,
  input  wire logic                      rx_word_valid,
  input  wire logic                      line_ready,
  output cops_mode_t                     mode_eff,
  output cops_cont_t                     content_eff,
  output cops_tim_t                      timing_eff,
  output cops_pat_t                      pattern_eff,
  output logic                           fec_active,
  output logic                           clk_present,
  output logic                           tx_enable,
  output logic [WORD_W-1:0]              tx_word,
  output logic                           tx_word_valid,
  output logic                           tx_framed,
  output logic                           rx_fec_active
);
  initial if (WORD_W != `COPS_USER_W) $error("cops_port: WORD_W must equal user word width");
  initial if (FIFO_DEPTH < 2) $error("cops_port: FIFO_DEPTH too small");

  cops_stream_if #(.W(WORD_W)) gen_s ();
  cops_stream_if #(.W(WORD_W)) line_s ();

  logic        det_ext_q1_r;
  logic        det_ext_q2_r;
  logic        det_gps_q1_r;
  logic        det_gps_q2_r;
  logic        det_rx_q1_r;
  logic        det_rx_q2_r;
  cops_mode_t  mode_nxt;
  cops_cont_t  cont_nxt;
  cops_tim_t   tim_nxt;
  cops_pat_t   pat_nxt;
  logic        fec_nxt;
  logic        present_nxt;
  logic [4:0]  order_r;
  logic [4:0]  order_nxt;
  logic        inv_r;
  logic        gen_valid_r;
  logic        gen_valid_nxt;
  logic        src_sel_r;
  logic        reseed;
  logic        advance;
  logic [WORD_W-1:0] prbs_word;
  logic [WORD_W-1:0] gen_data;
  logic        is_cpri_rate;
  logic        is_obsai_rate;
  logic        cfg_change;
  logic        tx_en_nxt;
  logic        tx_valid_nxt;
  logic [WORD_W-1:0] tx_word_nxt;

  // Clock-detect pins are asynchronous: two flops each
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      det_ext_q1_r <= 1'b0;
      det_ext_q2_r <= 1'b0;
      det_gps_q1_r <= 1'b0;
      det_gps_q2_r <= 1'b0;
      det_rx_q1_r  <= 1'b0;
      det_rx_q2_r  <= 1'b0;
    end
    else
    begin
      det_ext_q1_r <= ext_clk_det;
      det_ext_q2_r <= det_ext_q1_r;
      det_gps_q1_r <= gps_clk_det;
      det_gps_q2_r <= det_gps_q1_r;
      det_rx_q1_r  <= rx_clk_det;
      det_rx_q2_r  <= det_rx_q1_r;
    end
  end

  // Resolve requested settings into legal effective settings
  always_comb
  begin
    is_cpri_rate  = (rate_req < `COPS_RATE_OBSAI_LO);
    is_obsai_rate = (rate_req >= `COPS_RATE_OBSAI_LO) && (rate_req <= `COPS_RATE_MAX);
    mode_nxt = mode_req;
    cont_nxt = content_req;
    // Content must suit the rate family
    if (content_req == COPS_CONT_CPRI && !is_cpri_rate)
      cont_nxt = COPS_CONT_OBSAI;
    else if (content_req == COPS_CONT_OBSAI && !is_obsai_rate)
      cont_nxt = COPS_CONT_CPRI;
    else if (content_req != COPS_CONT_UNFRAMED && content_req != COPS_CONT_CPRI
             && content_req != COPS_CONT_OBSAI)
      cont_nxt = COPS_CONT_UNFRAMED;
    if (mode_req != COPS_MODE_OFF && mode_req != COPS_MODE_NORMAL && mode_req != COPS_MODE_THROUGH)
      mode_nxt = COPS_MODE_OFF;
    // Pass-through only with CPRI link; needs a CPRI rate
    if (mode_req == COPS_MODE_THROUGH)
    begin
      if (is_cpri_rate)
        cont_nxt = COPS_CONT_CPRI;
      else
        mode_nxt = COPS_MODE_NORMAL;
    end
    // Timing source, locked to recovered in pass-through
    tim_nxt = (mode_nxt == COPS_MODE_THROUGH) ? COPS_TIM_RECEIVED : timing_req;
    // Pattern restrictions for unframed content
    pat_nxt = pattern_req;
    if (pattern_req != COPS_PAT_PRBS && pattern_req != COPS_PAT_USER && pattern_req != COPS_PAT_OFF)
      pat_nxt = COPS_PAT_PRBS;
    if (cont_nxt == COPS_CONT_UNFRAMED)
      pat_nxt = COPS_PAT_PRBS;
    // Correction only at the two top CPRI rates
    fec_nxt = error_correction_enable
              && (rate_req == `COPS_RATE_CPRI_9 || rate_req == `COPS_RATE_CPRI_10);
    // Clock-present indicator for the selected source
    unique case (tim_nxt)
      COPS_TIM_EXTERNAL: present_nxt = det_ext_q2_r;
      COPS_TIM_GPS:      present_nxt = det_gps_q2_r;
      COPS_TIM_RECEIVED: present_nxt = det_rx_q2_r;
      default:           present_nxt = 1'b0;
    endcase
    // PRBS order clamped to 15..31
    order_nxt = (prbs_order_req < `COPS_ORD_MIN) ? `COPS_ORD_MIN : prbs_order_req;
  end

  // Effective settings register
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      mode_eff    <= COPS_MODE_OFF;
      content_eff <= COPS_CONT_UNFRAMED;
      timing_eff  <= COPS_TIM_INTERNAL;
      pattern_eff <= COPS_PAT_PRBS;
      fec_active  <= 1'b0;
      clk_present <= 1'b0;
      order_r     <= `COPS_ORD_MIN;
      inv_r       <= 1'b0;
    end
    else
    begin
      mode_eff    <= mode_nxt;
      content_eff <= cont_nxt;
      timing_eff  <= tim_nxt;
      pattern_eff <= pat_nxt;
      fec_active  <= fec_nxt;
      clk_present <= present_nxt;
      order_r     <= order_nxt;
      inv_r       <= invert_req;
    end
  end

  // Reseed the generator whenever the order or pattern changes
  assign cfg_change = (order_nxt != order_r) || (pat_nxt != pattern_eff);
  assign reseed     = cfg_change;
  assign advance    = gen_s.ready && !cfg_change;

  cops_prbs #(.W(WORD_W)) u_prbs (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .order   (order_r),
    .reseed  (reseed),
    .advance (advance),
    .word    (prbs_word)
  );

  // Pattern word source; PRBS inversion; user word repeats
  always_comb
  begin
    unique case (pattern_eff)
      COPS_PAT_USER: gen_data = user_word;
      COPS_PAT_OFF:  gen_data = '0;
      default:       gen_data = inv_r ? ~prbs_word : prbs_word;
    endcase
    gen_valid_nxt = (mode_eff == COPS_MODE_NORMAL) && (pattern_eff != COPS_PAT_OFF)
                    && !cfg_change;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gen_valid_r <= 1'b0;
      src_sel_r   <= 1'b0;
    end
    else
    begin
      gen_valid_r <= gen_valid_nxt;
      src_sel_r   <= (mode_eff == COPS_MODE_THROUGH);
    end
  end

  // Generated words or pass-through receive words enter the FIFO
  assign gen_s.data  = src_sel_r ? rx_word : gen_data;
  assign gen_s.valid = src_sel_r ? rx_word_valid : (gen_valid_r && (advance || pattern_eff == COPS_PAT_USER));

  cops_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .arst_n  (arst_n),
    .in_s    (gen_s),
    .out_s   (line_s)
  );

  // Line side: transmitter enable and registered word
  always_comb
  begin
    tx_en_nxt    = (mode_eff != COPS_MODE_OFF);
    line_s.ready = line_ready && tx_en_nxt;
    tx_valid_nxt = line_s.valid && line_s.ready;
    tx_word_nxt  = tx_valid_nxt ? line_s.data : '0;
  end

  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_enable     <= 1'b0;
      tx_word       <= '0;
      tx_word_valid <= 1'b0;
      tx_framed     <= 1'b0;
      rx_fec_active <= 1'b0;
    end
    else
    begin
      tx_enable     <= tx_en_nxt;
      tx_word       <= tx_word_nxt;
      tx_word_valid <= tx_valid_nxt;
      tx_framed     <= (content_eff != COPS_CONT_UNFRAMED);
      rx_fec_active <= fec_active;
    end
  end
endmodule
`default_nettype wire

/* File: verif/cops_line_model.sv */
// Far-side equipment model: line acceptance with stalls, received stream.
// Assumes ref_clk is shared with the port; stall comes from the bench.
`timescale 1ns/1ps
`default_nettype none
module cops_line_model (
  input  wire logic        ref_clk,
  input  wire logic        arst_n,
  input  wire logic        stall,
  output logic             line_ready,
  output logic [31:0]      rx_word,
  output logic             rx_word_valid,
  output logic             rx_clk_det
);
  logic [3:0] cnt_r;
  // Free-running beat counter
  always_ff @(posedge ref_clk or negedge arst_n)
  begin
    if (!arst_n)
      cnt_r <= 4'h0;
    else
      cnt_r <= cnt_r + 4'h1;
  end
  // One slow beat in four; words every other cycle, junk between
  assign line_ready    = !stall && (cnt_r[1:0] != 2'h3);
  assign rx_word_valid = cnt_r[0];
  assign rx_word       = cnt_r[0] ? {8{cnt_r}} : ~{8{cnt_r}};
  assign rx_clk_det    = arst_n;
endmodule
`default_nettype wire

/* File: verif/cops_port_sva.sv */
// Checker for the port setup block: resolved settings and line stream.
// Assumes binding onto cops_port; sees its ports only.
`timescale 1ns/1ps
`default_nettype none
module cops_port_sva
  import cops_pkg::*;
(
  input wire logic       ref_clk,
  input wire logic       arst_n,
  input wire cops_mode_t mode_req,
  input wire logic [3:0] rate_req,
  input wire cops_tim_t  timing_req,
  input wire logic       error_correction_enable,
  input wire logic       ext_clk_det,
  input wire logic       line_ready,
  input wire cops_mode_t mode_eff,
  input wire cops_cont_t content_eff,
  input wire cops_tim_t  timing_eff,
  input wire cops_pat_t  pattern_eff,
  input wire logic       fec_active,
  input wire logic       clk_present,
  input wire logic       tx_enable,
  input wire logic       tx_word_valid,
  input wire logic       tx_framed,
  input wire logic       rx_fec_active
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!arst_n);
  // Resolved settings and line activity
  AST_OFF_SILENT: assert property ((mode_req == COPS_MODE_OFF) [*4] |-> !tx_enable && !tx_word_valid)
    else $error("transmitter active in off mode");
  AST_TAKE: assert property (tx_word_valid |-> $past(line_ready && tx_enable))
    else $error("word sent without line acceptance");
  AST_THRU_CPRI: assert property (mode_eff == COPS_MODE_THROUGH |-> content_eff == COPS_CONT_CPRI)
    else $error("pass-through without cpri content");
  AST_THRU_RECV: assert property (mode_eff == COPS_MODE_THROUGH |-> timing_eff == COPS_TIM_RECEIVED)
    else $error("pass-through timing not received clock");
  AST_CLK_EXT: assert property ((mode_req != COPS_MODE_THROUGH && timing_req == COPS_TIM_EXTERNAL
    && ext_clk_det) [*4] |-> clk_present)
    else $error("external clock present not shown");
  AST_CLK_INT: assert property ((timing_eff == COPS_TIM_INTERNAL) [*4] |-> !clk_present)
    else $error("clock present with internal timing");
  AST_FEC_RATE: assert property (fec_active |-> $past(error_correction_enable) && $past(rate_req) inside {4'h8, 4'h9})
    else $error("correction active at wrong rate");
  AST_RX_FEC: assert property (fec_active |=> rx_fec_active)
    else $error("receive correction not following");
  AST_RATE_FAM: assert property ($past(rate_req) >= 4'hA |-> content_eff != COPS_CONT_CPRI)
    else $error("cpri content at obsai rate");
  AST_BARE: assert property ((content_eff == COPS_CONT_UNFRAMED) [*2] |-> !tx_framed)
    else $error("framing flagged for unframed content");
  AST_UNF_PAT: assert property (content_eff == COPS_CONT_UNFRAMED |-> pattern_eff == COPS_PAT_PRBS)
    else $error("user or off pattern with unframed content");
  // Main scenarios reached
  COV_THRU: cover property (mode_eff == COPS_MODE_THROUGH);
  COV_FEC: cover property (fec_active);
  COV_STALL: cover property (!line_ready [*3] ##1 line_ready ##1 tx_word_valid);
endmodule
bind cops_port cops_port_sva u_sva (.ref_clk, .arst_n, .mode_req, .rate_req, .timing_req,
  .error_correction_enable, .ext_clk_det, .line_ready, .mode_eff, .content_eff, .timing_eff,
  .pattern_eff, .fec_active, .clk_present, .tx_enable, .tx_word_valid, .tx_framed, .rx_fec_active);
`default_nettype wire

/* File: verif/tb_top.sv */
// Bench for the port setup block: settings, pattern stream, line stalls.
// Assumes design sources, checker and line model compiled before it.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import cops_pkg::*;
;
  logic ref_clk, arst_n, fec, inv, stall, ext_det, gps_det;
  logic line_ready, rx_valid, rx_det, fec_a, clk_p, tx_en, txv, framed, rxfec;
  logic [3:0] rate;
  logic [4:0] ord;
  logic [31:0] uword, rx_word, tx_word;
  cops_mode_t mode, mode_e;
  cops_cont_t cont, cont_e;
  cops_tim_t tim, tim_e;
  cops_pat_t pat, pat_e;
  int num_errors = 0;
  int n_tests = 0;
  cops_port dut (.ref_clk(ref_clk), .arst_n(arst_n), .mode_req(mode), .content_req(cont), .rate_req(rate),
    .timing_req(tim), .error_correction_enable(fec), .pattern_req(pat), .prbs_order_req(ord),
    .invert_req(inv), .user_word(uword), .ext_clk_det(ext_det), .gps_clk_det(gps_det),
    .rx_clk_det(rx_det), .rx_word(rx_word), .rx_word_valid(rx_valid), .line_ready(line_ready),
    .mode_eff(mode_e), .content_eff(cont_e), .timing_eff(tim_e), .pattern_eff(pat_e),
    .fec_active(fec_a), .clk_present(clk_p), .tx_enable(tx_en), .tx_word(tx_word),
    .tx_word_valid(txv), .tx_framed(framed), .rx_fec_active(rxfec));
  cops_line_model partner (.ref_clk(ref_clk), .arst_n(arst_n), .stall(stall), .line_ready(line_ready),
    .rx_word(rx_word), .rx_word_valid(rx_valid), .rx_clk_det(rx_det));
  // Clock generator
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // Compare tasks and helpers
  task automatic chkw(string nm, logic [31:0] e, logic [31:0] g);
    n_tests++;
    if (g !== e)
    begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic cfg(cops_mode_t m, cops_cont_t c, logic [3:0] r, cops_pat_t p);
    mode = m;
    cont = c;
    rate = r;
    pat = p;
    repeat (5) @(posedge ref_clk);
    #1;
  endtask
  task automatic grab(output logic [31:0] w);
    for (int k = 0; k < 60; k++)
    begin
      @(posedge ref_clk);
      #1;
      if (txv === 1'b1)
        break;
    end
    chkw("word wait", 32'h1, {31'h0, txv});
    w = tx_word;
  endtask
  // Scenarios
  task automatic t_modes;
    cfg(COPS_MODE_OFF, COPS_CONT_CPRI, 4'h2, COPS_PAT_PRBS);
    chkw("tx_enable off", 32'h0, {31'h0, tx_en});
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h2, COPS_PAT_PRBS);
    chkw("tx_enable normal", 32'h1, {31'h0, tx_en});
  endtask
  task automatic t_through;
    logic [31:0] w;
    cfg(COPS_MODE_THROUGH, COPS_CONT_OBSAI, 4'h9, COPS_PAT_PRBS);
    grab(w);
    chkw("through word", {8{w[3:0]}}, w);
    chkw("through odd", 32'h1, {31'h0, w[0]});
    chkw("mode", 32'(COPS_MODE_THROUGH), 32'(mode_e));
    chkw("content", 32'(COPS_CONT_CPRI), 32'(cont_e));
    chkw("timing", 32'(COPS_TIM_RECEIVED), 32'(tim_e));
    chkw("clk recv", 32'h1, {31'h0, clk_p});
    cfg(COPS_MODE_THROUGH, COPS_CONT_CPRI, 4'hB, COPS_PAT_PRBS);
    chkw("mode obsai", 32'(COPS_MODE_NORMAL), 32'(mode_e));
    tim = COPS_TIM_EXTERNAL;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h2, COPS_PAT_PRBS);
    chkw("clk ext lost", 32'h0, {31'h0, clk_p});
    ext_det = 1'b1;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h2, COPS_PAT_PRBS);
    chkw("clk ext", 32'h1, {31'h0, clk_p});
    tim = COPS_TIM_GPS;
    gps_det = 1'b1;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h2, COPS_PAT_PRBS);
    chkw("clk gps", 32'h1, {31'h0, clk_p});
    tim = COPS_TIM_INTERNAL;
  endtask
  task automatic t_fec;
    fec = 1'b1;
    for (int r = 0; r < 10; r++)
    begin
      cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'(r), COPS_PAT_PRBS);
      chkw("fec", {31'h0, r >= 8}, {31'h0, fec_a});
      chkw("rx fec", {31'h0, r >= 8}, {31'h0, rxfec});
    end
    fec = 1'b0;
  endtask
  task automatic t_content;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'hA, COPS_PAT_PRBS);
    chkw("cont obsai", 32'(COPS_CONT_OBSAI), 32'(cont_e));
    cfg(COPS_MODE_NORMAL, COPS_CONT_OBSAI, 4'h3, COPS_PAT_PRBS);
    chkw("cont cpri", 32'(COPS_CONT_CPRI), 32'(cont_e));
    cfg(COPS_MODE_NORMAL, COPS_CONT_UNFRAMED, 4'h3, COPS_PAT_USER);
    chkw("pat user", 32'(COPS_PAT_PRBS), 32'(pat_e));
    chkw("framed", 32'h0, {31'h0, framed});
    cfg(COPS_MODE_NORMAL, COPS_CONT_UNFRAMED, 4'h3, COPS_PAT_OFF);
    chkw("pat off", 32'(COPS_PAT_PRBS), 32'(pat_e));
  endtask
  task automatic t_user_off;
    logic [31:0] w;
    int cnt;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h3, COPS_PAT_USER);
    repeat (20) @(posedge ref_clk);
    for (int i = 0; i < 3; i++)
    begin
      grab(w);
      chkw("user word", uword, w);
    end
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h3, COPS_PAT_OFF);
    repeat (20) @(posedge ref_clk);
    cnt = 0;
    repeat (16)
    begin
      @(posedge ref_clk);
      #1;
      cnt += int'(txv === 1'b1);
    end
    chkw("off words", 32'h0, 32'(cnt));
    chkw("off enable", 32'h1, {31'h0, tx_en});
  endtask
  task automatic t_prbs(logic [4:0] o, int t, logic iv);
    logic [159:0] s;
    logic [31:0] w;
    int bad;
    ord = o;
    inv = iv;
    cfg(COPS_MODE_NORMAL, COPS_CONT_CPRI, 4'h3, COPS_PAT_PRBS);
    repeat (30) @(posedge ref_clk);
    #1;
    stall = 1'b1;
    repeat (12) @(posedge ref_clk);
    #1;
    stall = 1'b0;
    bad = 0;
    for (int i = 0; i < 5; i++)
    begin
      grab(w);
      s = {s[127:0], w};
    end
    for (int n = o; n < 160; n++)
      bad += int'((s[159-n] ^ s[159-n+t] ^ s[159-n+o]) !== iv);
    chkw("prbs", 32'h0, 32'(bad));
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    int ords[11] = '{15, 17, 18, 20, 21, 22, 23, 25, 28, 29, 31};
    int taps[11] = '{14, 14, 11, 17, 19, 21, 18, 22, 25, 27, 28};
    arst_n = 1'b0;
    {fec, inv, stall, ext_det, gps_det} = 5'h0;
    mode = COPS_MODE_OFF;
    cont = COPS_CONT_UNFRAMED;
    tim = COPS_TIM_INTERNAL;
    pat = COPS_PAT_PRBS;
    rate = 4'h2;
    ord = 5'h0F;
    uword = 32'hA5C30F1E;
    repeat (20) @(posedge ref_clk);
    #1;
    arst_n = 1'b1;
    t_modes();
    t_through();
    t_fec();
    t_content();
    t_user_off();
    for (int i = 0; i < 11; i++)
      t_prbs(5'(ords[i]), taps[i], i[0]);
    final_report();
  end
  // Watchdog
  initial
  begin
    #100000;
    num_errors++;
    final_report();
  end
endmodule
`default_nettype wire
